// file: hdl/fcr_pin_mux.sv
// Purpose: output-enable steering of local bus pins
// Assumes: enable inputs already synchronised and registered
// Notes:   enables are high while the device drives the pin
`timescale 1ns/1ps
module fcr_pin_mux (
    // configuration
    input  wire logic pin_cfg_active,
    input  wire logic loe_high,
    // core bus drive request
    input  wire logic bus_drive_req,
    // pin enables
    output logic      col_strobe_oe,
    output logic      write_strobe_oe,
    output logic      coproc_ready_oe,
    output logic      coproc_interrupt_oe,
    output logic      address_latch_oe,
    output logic      local_address_data_oe
);
    logic float_pins;

    // --------------------------------------------------------------
    // tristate steering
    // --------------------------------------------------------------
    assign float_pins            = pin_cfg_active & loe_high;
    assign col_strobe_oe         = ~float_pins;
    assign write_strobe_oe       = ~float_pins;
    assign coproc_ready_oe       = 1'b1;
    assign coproc_interrupt_oe   = 1'b1;
    assign address_latch_oe      = 1'b1;
    assign local_address_data_oe = bus_drive_req & ~float_pins;
endmodule

// file: hdl/fcr_pkg.sv
// Purpose: constants for the fpu setup register, upper field block
// Assumes: internal 5-bit register addressing by move instructions
// Notes:   bits 6..0 live outside this block and read as zero here
package fcr_pkg;
    // ------------------------------------------------------------
    // register address and geometry
    // ------------------------------------------------------------
    localparam logic [4:0]  SETUP_REG_ADDR  = 5'h0d;
    localparam int          REG_W           = 32;
    localparam int          MUL_EXC_N       = 6;
    localparam int          ALU_EXC_N       = 5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          MUL_EN_LSB      = 26;
    localparam int          ALU_EN_LSB      = 21;
    localparam int          RSVD_HI_MSB     = 20;
    localparam int          RSVD_HI_LSB     = 11;
    localparam int          REVISION_BIT    = 10;
    localparam int          PIN_CFG_BIT     = 9;
    localparam int          MEM_CFG_BIT     = 8;
    localparam int          RSVD_LO_BIT     = 7;

    // ------------------------------------------------------------
    // reset and write masks
    // ------------------------------------------------------------
    localparam logic [31:0] SETUP_RESET     = 32'hffe00000;
    localparam logic [31:0] SETUP_WR_MASK   = 32'hffe00300;
    // arbitrary neutral value, not the shipped revision
    localparam logic        REVISION_VALUE  = 1'b0;
endpackage

// file: hdl/fcr_top.sv
// Purpose: upper fields of the fpu setup register and their pin effects
// Assumes: move instructions supply address, strobe and data each cycle
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/1ps
module fcr_top #(
    parameter logic REVISION_ID = fcr_pkg::REVISION_VALUE
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // move instruction register access
    input  wire logic        move_wr_en,
    input  wire logic [4:0]  move_wr_addr,
    input  wire logic [31:0] move_wr_data,
    input  wire logic [4:0]  move_rd_addr,
    output logic [31:0]      move_rd_data,
    output logic             move_rd_hit,
    // fpu operand source check
    input  wire logic        fpu_src_valid,
    input  wire logic [4:0]  fpu_src_a_addr,
    input  wire logic [4:0]  fpu_src_b_addr,
    output logic             fpu_src_illegal,
    // field outputs
    output logic [5:0]       mul_exc_enables,
    output logic [4:0]       alu_exc_enables,
    output logic             local_bus_pin_config,
    output logic             program_memory_select_config,
    // exception events
    input  wire logic [5:0]  mul_exc_event,
    input  wire logic [4:0]  alu_exc_event,
    input  wire logic        exception_flag_clear,
    output logic             exception_flag_sticky,
    // mode
    input  wire logic        coprocessor_mode,
    // local bus pin sources from the core
    input  wire logic        local_output_enable_n,
    input  wire logic        col_strobe_core,
    input  wire logic        write_strobe_core,
    input  wire logic        coproc_ready_core,
    input  wire logic        address_latch_core,
    input  wire logic        set_mask_interrupt,
    input  wire logic        bus_move_active,
    input  wire logic        bus_move_boundary_bit,
    input  wire logic        bus_drive_req,
    input  wire logic [31:0] bus_data_core,
    // local bus pins
    output logic             col_strobe_out,
    output logic             col_strobe_oe,
    output logic             write_strobe_out,
    output logic             write_strobe_oe,
    output logic             coproc_ready_out,
    output logic             coproc_ready_oe,
    output logic             coproc_interrupt_out,
    output logic             coproc_interrupt_oe,
    output logic             address_latch_strobe,
    output logic             address_latch_oe,
    output logic [31:0]      local_address_data_bus,
    output logic             local_address_data_oe,
    // program memory select
    input  wire logic        mem_access,
    input  wire logic        mem_data_space,
    output logic             memory_chip_enable,
    output logic             space_select_pin
);
    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    logic [31:0] setup_r;
    logic [31:0] setup_nxt;
    logic [31:0] setup_view;
    logic [31:0] rd_data_r;
    logic        rd_hit_r;
    logic        src_illegal_r;
    logic        exc_flag_r;
    logic [10:0] exc_enable;
    logic [10:0] exc_event;
    logic [10:0] exc_gated;
    logic        loe_s1_r;
    logic        loe_s2_r;
    logic        loe_s3_r;
    logic        loe_high_r;
    logic        pin_cfg_active;
    logic        col_strobe_r;
    logic        write_strobe_r;
    logic        ready_r;
    logic        interrupt_r;
    logic        latch_r;
    logic [31:0] bus_data_r;
    logic        mce_r;
    logic        space_r;

    function automatic logic is_setup_addr(input logic [4:0] addr);
        is_setup_addr = (addr == fcr_pkg::SETUP_REG_ADDR);
    endfunction

    // --------------------------------------------------------------
    // register write
    // --------------------------------------------------------------
    always_comb begin
        setup_nxt = setup_r;
        if (move_wr_en && is_setup_addr(move_wr_addr)) begin
            setup_nxt = (move_wr_data & fcr_pkg::SETUP_WR_MASK)
                      | (setup_r & ~fcr_pkg::SETUP_WR_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            setup_r <= fcr_pkg::SETUP_RESET;
        end else begin
            setup_r <= setup_nxt;
        end
    end

    // reserved and revision bits forced on every read
    always_comb begin
        setup_view = setup_r & fcr_pkg::SETUP_WR_MASK;
        setup_view[fcr_pkg::REVISION_BIT] = REVISION_ID;
    end

    assign mul_exc_enables              = setup_view[31:fcr_pkg::MUL_EN_LSB];
    assign alu_exc_enables              = setup_view[25:fcr_pkg::ALU_EN_LSB];
    assign local_bus_pin_config         = setup_view[fcr_pkg::PIN_CFG_BIT];
    assign program_memory_select_config = setup_view[fcr_pkg::MEM_CFG_BIT];

    // --------------------------------------------------------------
    // register read and source check
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_r <= 32'h0000_0000;
            rd_hit_r  <= 1'b0;
        end else begin
            rd_hit_r  <= is_setup_addr(move_rd_addr);
            rd_data_r <= is_setup_addr(move_rd_addr) ? setup_view : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            src_illegal_r <= 1'b0;
        end else begin
            src_illegal_r <= fpu_src_valid
                           & (is_setup_addr(fpu_src_a_addr) | is_setup_addr(fpu_src_b_addr));
        end
    end

    assign move_rd_data    = rd_data_r;
    assign move_rd_hit     = rd_hit_r;
    assign fpu_src_illegal = src_illegal_r;

    // --------------------------------------------------------------
    // exception detection
    // --------------------------------------------------------------
    assign exc_enable = {mul_exc_enables, alu_exc_enables};
    assign exc_event  = {mul_exc_event, alu_exc_event};

    genvar gi;
    generate
        for (gi = 0; gi < fcr_pkg::MUL_EXC_N + fcr_pkg::ALU_EXC_N; gi++) begin : g_exc
            assign exc_gated[gi] = exc_event[gi] & exc_enable[gi];
        end
    endgenerate

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            exc_flag_r <= 1'b0;
        end else if (|exc_gated) begin
            exc_flag_r <= 1'b1;
        end else if (exception_flag_clear) begin
            exc_flag_r <= 1'b0;
        end
    end

    assign exception_flag_sticky = exc_flag_r;

    // --------------------------------------------------------------
    // output-enable pin synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            loe_s1_r <= 1'b1;
            loe_s2_r <= 1'b1;
            loe_s3_r <= 1'b1;
        end else begin
            loe_s1_r <= local_output_enable_n;
            loe_s2_r <= loe_s1_r;
            loe_s3_r <= loe_s2_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            loe_high_r <= 1'b1;
        end else if (loe_s2_r == loe_s3_r) begin
            loe_high_r <= loe_s3_r;
        end
    end

    assign pin_cfg_active = local_bus_pin_config & ~coprocessor_mode;

    fcr_pin_mux u_pin_mux (
        .pin_cfg_active        (pin_cfg_active),
        .loe_high              (loe_high_r),
        .bus_drive_req         (bus_drive_req),
        .col_strobe_oe         (col_strobe_oe),
        .write_strobe_oe       (write_strobe_oe),
        .coproc_ready_oe       (coproc_ready_oe),
        .coproc_interrupt_oe   (coproc_interrupt_oe),
        .address_latch_oe      (address_latch_oe),
        .local_address_data_oe (local_address_data_oe)
    );

    // --------------------------------------------------------------
    // local bus pin data
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            col_strobe_r   <= 1'b1;
            write_strobe_r <= 1'b1;
            ready_r        <= 1'b1;
            latch_r        <= 1'b0;
            bus_data_r     <= 32'h0000_0000;
        end else begin
            col_strobe_r   <= col_strobe_core;
            write_strobe_r <= write_strobe_core;
            ready_r        <= coproc_ready_core;
            latch_r        <= address_latch_core;
            bus_data_r     <= bus_data_core;
        end
    end

    // interrupt pin doubles as bus cycle boundary marker
    always_ff @(posedge clk) begin
        if (reset) begin
            interrupt_r <= 1'b1;
        end else if (pin_cfg_active) begin
            interrupt_r <= ~(bus_move_active & bus_move_boundary_bit);
        end else begin
            interrupt_r <= set_mask_interrupt;
        end
    end

    assign col_strobe_out         = col_strobe_r;
    assign write_strobe_out       = write_strobe_r;
    assign coproc_ready_out       = ready_r;
    assign coproc_interrupt_out   = interrupt_r;
    assign address_latch_strobe   = latch_r;
    assign local_address_data_bus = bus_data_r;

    // --------------------------------------------------------------
    // program memory selects, chip enable active low, space pin active low in split mode only
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mce_r   <= 1'b1;
            space_r <= 1'b0;
        end else if (program_memory_select_config) begin
            mce_r   <= ~(mem_access & ~mem_data_space);
            space_r <= ~(mem_access & mem_data_space);
        end else begin
            mce_r   <= ~mem_access;
            space_r <= mem_data_space;
        end
    end

    assign memory_chip_enable = mce_r;
    assign space_select_pin   = space_r;
endmodule

// file: sim/fcr_monitor.sv
// Purpose: port checks for the fpu setup register block
// Assumes: sync active-high reset, one clock
// Notes:   bound from the bench top
`timescale 1ns/1ps
module fcr_monitor #(
    parameter logic REVISION_ID = 1'b0
) (
    // clock, reset, register access
    input wire logic        clk, reset, move_wr_en, move_rd_hit, fpu_src_valid, fpu_src_illegal,
    input wire logic [4:0]  move_wr_addr, move_rd_addr, fpu_src_a_addr, fpu_src_b_addr,
    input wire logic [31:0] move_wr_data, move_rd_data,
    // fields and exceptions
    input wire logic [5:0]  mul_exc_enables, mul_exc_event,
    input wire logic [4:0]  alu_exc_enables, alu_exc_event,
    input wire logic        local_bus_pin_config, program_memory_select_config, exception_flag_sticky,
    // pins
    input wire logic        coprocessor_mode, local_output_enable_n, bus_move_active, bus_move_boundary_bit,
    input wire logic        col_strobe_oe, write_strobe_oe, local_address_data_oe, coproc_interrupt_out,
    input wire logic        bus_drive_req, coproc_ready_oe, coproc_interrupt_oe, address_latch_oe,
    input wire logic        mem_access, mem_data_space, memory_chip_enable, space_select_pin
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic wr_hit = move_wr_en && move_wr_addr == 5'h0d && !reset;
    wire logic exc_on = |(mul_exc_event & mul_exc_enables) || |(alu_exc_event & alu_exc_enables);
    wire logic pin_on = local_bus_pin_config && !coprocessor_mode;

    rd_hit_a: assert property (!$past(reset) |-> move_rd_hit == ($past(move_rd_addr) == 5'h0d))
        else $error("read hit wrong");
    reset_val_a: assert property ($past(reset) |->
        {mul_exc_enables, alu_exc_enables} == 11'h7ff && !local_bus_pin_config && !program_memory_select_config)
        else $error("reset value wrong");
    rsvd_zero_a: assert property (move_rd_data[20:11] == 10'h0 && move_rd_data[7:0] == 8'h0)
        else $error("reserved bits set");
    rev_bit_a: assert property (move_rd_hit |-> move_rd_data[10] == REVISION_ID)
        else $error("revision bit wrong");
    wr_fields_a: assert property (wr_hit |=>
        {mul_exc_enables, alu_exc_enables} == $past(move_wr_data[31:21])
        && local_bus_pin_config == $past(move_wr_data[9])
        && program_memory_select_config == $past(move_wr_data[8]))
        else $error("fields not written");
    exc_set_a: assert property (exc_on |=> exception_flag_sticky)
        else $error("enabled exception lost");
    exc_off_a: assert property (!exc_on && !exception_flag_sticky |=> !exception_flag_sticky)
        else $error("flag set without cause");
    oe_drive_a: assert property (!pin_on |->
        col_strobe_oe && write_strobe_oe && local_address_data_oe == bus_drive_req)
        else $error("pins floated");
    fixed_oe_a: assert property (coproc_ready_oe && coproc_interrupt_oe && address_latch_oe)
        else $error("fixed pins not driven");
    pins_float_a: assert property ((pin_on && local_output_enable_n) [*5] |->
        !col_strobe_oe && !write_strobe_oe && !local_address_data_oe)
        else $error("pins not floated");
    irq_boundary_a: assert property (pin_on |=>
        coproc_interrupt_out == !$past(bus_move_active && bus_move_boundary_bit))
        else $error("interrupt boundary wrong");
    mem_select_a: assert property (mem_access |=>
        $past(program_memory_select_config)
        ? (memory_chip_enable == $past(mem_data_space) && space_select_pin == !$past(mem_data_space))
        : (!memory_chip_enable && space_select_pin == $past(mem_data_space)))
        else $error("memory select wrong");
    src_refuse_a: assert property (fpu_src_valid &&
        (fpu_src_a_addr == 5'h0d || fpu_src_b_addr == 5'h0d) |=> fpu_src_illegal)
        else $error("source not refused");

    c_wr_c: cover property (wr_hit);
    c_exc_c: cover property (exc_on);
    c_flt_c: cover property (pin_on && !col_strobe_oe);
endmodule

// file: sim/fcr_pmem_model.sv
// Purpose: external program memory select decode
// Assumes: active-low enables from the block
// Notes:   reports which space a memory access lands in
`timescale 1ns/1ps
module fcr_pmem_model (
    // pins
    input wire logic memory_chip_enable,
    input wire logic space_select_pin,
    input wire logic split_mode,
    // decoded selects
    output logic     code_sel,
    output logic     data_sel
);
    assign code_sel = split_mode ? !memory_chip_enable : !memory_chip_enable && !space_select_pin;
    assign data_sel = split_mode ? !space_select_pin : !memory_chip_enable && space_select_pin;
endmodule

// file: sim/fcr_top_tb_top.sv
// Purpose: directed bench for the fpu setup register block
// Assumes: inputs driven 2 ns after rising edge
// Notes:   revision parameter value is arbitrary
`timescale 1ns/1ps
module fcr_top_tb_top;
    localparam logic REV = 1'b1;
    logic clk = 0, reset = 1, move_wr_en = 0, fpu_src_valid = 0, exception_flag_clear = 0, coprocessor_mode = 0;
    logic [4:0] move_wr_addr = 0, move_rd_addr = 0, fpu_src_a_addr = 0, fpu_src_b_addr = 0, alu_exc_event = 0;
    logic [31:0] move_wr_data = 0, bus_data_core = 0, move_rd_data, local_address_data_bus;
    logic [5:0] mul_exc_event = 0, mul_exc_enables;
    logic [4:0] alu_exc_enables;
    logic local_output_enable_n = 0, col_strobe_core = 1, write_strobe_core = 1, coproc_ready_core = 1;
    logic address_latch_core = 0, set_mask_interrupt = 1, bus_move_active = 0, bus_move_boundary_bit = 0;
    logic bus_drive_req = 1, mem_access = 0, mem_data_space = 0, code_sel, data_sel;
    logic move_rd_hit, fpu_src_illegal, local_bus_pin_config, program_memory_select_config;
    logic exception_flag_sticky, col_strobe_out, col_strobe_oe, write_strobe_out, write_strobe_oe;
    logic coproc_ready_out, coproc_ready_oe, coproc_interrupt_out, coproc_interrupt_oe, address_latch_strobe;
    logic address_latch_oe, local_address_data_oe, memory_chip_enable, space_select_pin;
    int failures = 0, checks = 0, cyc = 0;
    logic [31:0] d;
    logic h;

    fcr_top #(.REVISION_ID(REV)) dut (.*);
    fcr_pmem_model pmem (.memory_chip_enable(memory_chip_enable), .space_select_pin(space_select_pin),
        .split_mode(program_memory_select_config), .code_sel(code_sel), .data_sel(data_sel));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] v);
        move_wr_en = 1;
        move_wr_addr = a;
        move_wr_data = v;
        tick();
        move_wr_en = 0;
    endtask
    task automatic rd(logic [4:0] a);
        move_rd_addr = a;
        tick();
        d = move_rd_data;
        h = move_rd_hit;
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(5'h0d);
        chk(d, {11'h7ff, 10'h0, REV, 10'h0});
        chk({h, mul_exc_enables, alu_exc_enables}, 12'hfff);
        chk({local_bus_pin_config, program_memory_select_config}, 2'b00);
    endtask
    task automatic t_write();
        wr(5'h0d, 32'hffffffff);
        rd(5'h0d);
        chk(d, {11'h7ff, 10'h0, REV, 2'b11, 8'h0});
        wr(5'h0d, 32'h0);
        tick();
        wr(5'h0e, 32'hffffffff);
        rd(5'h0d);
        chk(d, {21'h0, REV, 10'h0});
        rd(5'h0e);
        chk(d, 0);
        chk(h, 0);
        fpu_src_valid = 1;
        fpu_src_a_addr = 5'h0d;
        tick();
        chk(fpu_src_illegal, 1);
        fpu_src_a_addr = 5'h0c;
        fpu_src_b_addr = 5'h0d;
        tick();
        chk(fpu_src_illegal, 1);
        fpu_src_b_addr = 5'h0e;
        tick();
        chk(fpu_src_illegal, 0);
        fpu_src_valid = 0;
    endtask
    task automatic t_exc();
        mul_exc_event = 6'h3f;
        alu_exc_event = 5'h1f;
        tick(2);
        chk(exception_flag_sticky, 0);
        wr(5'h0d, 32'h04000000);
        mul_exc_event = 6'h3e;
        tick(2);
        chk(exception_flag_sticky, 0);
        mul_exc_event = 6'h01;
        tick();
        chk(exception_flag_sticky, 1);
        mul_exc_event = 0;
        alu_exc_event = 0;
        exception_flag_clear = 1;
        tick();
        exception_flag_clear = 0;
        chk(exception_flag_sticky, 0);
        wr(5'h0d, 32'h00200000);
        alu_exc_event = 5'h01;
        exception_flag_clear = 1;
        tick();
        alu_exc_event = 0;
        chk(exception_flag_sticky, 1);
        tick();
        exception_flag_clear = 0;
        chk(exception_flag_sticky, 0);
    endtask
    task automatic t_pins();
        local_output_enable_n = 1;
        col_strobe_core = 0;
        write_strobe_core = 0;
        coproc_ready_core = 0;
        address_latch_core = 1;
        bus_data_core = 32'ha5c3_0f96;
        tick(5);
        chk({col_strobe_oe, write_strobe_oe, local_address_data_oe, col_strobe_out}, 4'b1110);
        chk({write_strobe_out, coproc_ready_out, address_latch_strobe}, 3'b001);
        chk(local_address_data_bus, 32'ha5c3_0f96);
        bus_drive_req = 0;
        tick();
        chk(local_address_data_oe, 0);
        bus_drive_req = 1;
        wr(5'h0d, 32'h00000200);
        tick(5);
        chk({col_strobe_oe, write_strobe_oe, local_address_data_oe}, 3'b000);
        chk({coproc_ready_oe, coproc_interrupt_oe, address_latch_oe}, 3'b111);
        coprocessor_mode = 1;
        tick();
        chk({col_strobe_oe, write_strobe_oe, local_address_data_oe}, 3'b111);
        coprocessor_mode = 0;
        local_output_enable_n = 0;
        set_mask_interrupt = 0;
        bus_move_active = 1;
        tick(5);
        chk({col_strobe_oe, coproc_interrupt_out}, 2'b11);
        bus_move_boundary_bit = 1;
        tick();
        chk(coproc_interrupt_out, 0);
        wr(5'h0d, 32'h0);
        set_mask_interrupt = 1;
        tick();
        chk(coproc_interrupt_out, 1);
    endtask
    task automatic t_mem();
        mem_access = 1;
        for (int m = 0; m < 4; m++) begin
            if (m == 2)
                wr(5'h0d, 32'h00000100);
            mem_data_space = m[0];
            tick();
            chk({memory_chip_enable, space_select_pin}, m[1] ? {m[0], !m[0]} : {1'b0, m[0]});
            chk({code_sel, data_sel}, m[0] ? 2'b01 : 2'b10);
        end
        mem_access = 0;
    endtask

    initial begin
        tick(4);
        reset = 0;
        t_reset();
        t_write();
        t_exc();
        t_pins();
        t_mem();
        end_sim();
    end
endmodule

bind fcr_top fcr_monitor #(.REVISION_ID(REVISION_ID)) mon (.*);
